// ==== pkg/fpv_cfg.svh ====
`ifndef FPV_CFG_SVH
`define FPV_CFG_SVH

`define FPV_OFS_FCR        8'h00
`define FPV_OFS_BSR1       8'h04
`define FPV_OFS_BSR2       8'h08
`define FPV_OFS_WOCR       8'h0c
`define FPV_OFS_STATUS     8'h10
`define FPV_OFS_IMASK      8'h14

`define FPV_FCR_PROG       0
`define FPV_FCR_ERASE      1
`define FPV_FCR_PVER       2
`define FPV_FCR_EVER       3
`define FPV_WOCR_SEL_HI    7
`define FPV_WOCR_SEL_LO    6

`define FPV_RST_FCR        4'h0
`define FPV_RST_BSR        8'h00
`define FPV_RST_WOCR       8'h08
`define FPV_BOOT_OVL       2'h3

`define FPV_CLK_NS         40
`define FPV_PWV_SETTLE_NS  4000
`define FPV_PWV_SETTLE_CYC \
    ((`FPV_PWV_SETTLE_NS + `FPV_CLK_NS - 1) / `FPV_CLK_NS)

`define FPV_OVL_RAM_BASE   16'hf800
`define FPV_OVL_VEC_END    16'h007f
`define FPV_OVL_ONE_LO     16'h0080
`define FPV_OVL_ONE_HI     16'h00ff
`define FPV_OVL_TWO_HI     16'h017f

`endif

// ==== pkg/fpv_pkg.sv ====
package fpv_pkg;

    typedef enum logic [3:0] {
        FPV_OP_IDLE  = 4'h1,
        FPV_OP_PROG  = 4'h2,
        FPV_OP_ERASE = 4'h4,
        FPV_OP_ABORT = 4'h8
    } fpv_op_e;

    typedef struct packed {
        fpv_op_e     op;
        logic [3:0]  fcr;
        logic [7:0]  bsr1;
        logic [7:0]  bsr2;
        logic [7:0]  wocr;
        logic        imask;
        logic        lock;
        logic        boot_pend;
        logic [6:0]  settle;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [15:0] prog_en;
        logic [15:0] erase_en;
        logic        pv;
        logic        ev;
        logic        pwv;
        logic        pwv_rdy;
        logic        rd_inv;
        logic        ovl_hit;
        logic [15:0] ovl_addr;
    } fpv_state_s;

endpackage

// ==== logic/fpv_overlay_map.sv ====
`timescale 1ns/1ns
`include "fpv_cfg.svh"

module fpv_overlay_map
(
    input  wire logic        sel_hi_i,
    input  wire logic        sel_lo_i,
    input  wire logic        vpp_ok_i,
    input  wire logic [15:0] cpu_addr_i,
    output logic             hit_o,
    output logic [15:0]      ram_addr_o
);

    // Every overlay window keeps the low address bits, so the RAM address
    // is always the same offset from the flash address.
    always_comb
    begin
        hit_o      = 1'b0;
        ram_addr_o = cpu_addr_i + `FPV_OVL_RAM_BASE;
        case ({sel_hi_i, sel_lo_i})
            2'b01:
            begin
                hit_o = (cpu_addr_i >= `FPV_OVL_ONE_LO) &&
                        (cpu_addr_i <= `FPV_OVL_ONE_HI);
            end
            2'b10:
            begin
                hit_o = (cpu_addr_i >= `FPV_OVL_ONE_LO) &&
                        (cpu_addr_i <= `FPV_OVL_TWO_HI);
            end
            2'b11:
            begin
                hit_o = vpp_ok_i &&
                        (cpu_addr_i <= `FPV_OVL_VEC_END);
            end
            default:
            begin
                hit_o = 1'b0;
            end
        endcase
    end

endmodule

// ==== logic/fpv_top.sv ====
`timescale 1ns/1ns
`include "fpv_cfg.svh"

module fpv_top
(
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        vpp_ok_i,
    input  wire logic        standby_i,
    input  wire logic        boot_mode_i,
    input  wire logic        irq_i,
    input  wire logic        nmi_i,
    input  wire logic [15:0] cpu_addr_i,
    output logic [15:0]      prog_en_o,
    output logic [15:0]      erase_en_o,
    output logic             pv_mode_o,
    output logic             ev_mode_o,
    output logic             pwv_mode_o,
    output logic             pwv_ready_o,
    output logic             read_invalid_o,
    output logic             locked_o,
    output logic             ovl_hit_o,
    output logic [15:0]      ovl_addr_o
);

    // The count starts at one on the entry edge, so the full figure is used.
    localparam logic [6:0] SETTLE_MAX = 7'(`FPV_PWV_SETTLE_CYC);

    logic                rst_meta_r;
    logic                rst_sync_r;
    fpv_pkg::fpv_state_s s_r;
    fpv_pkg::fpv_state_s s_nxt;
    logic                hw_prot;
    logic                emu_prot;
    logic                allow;
    logic                int_evt;
    logic                setup;
    logic                wr;
    logic                map_hit;
    logic [15:0]         map_addr;
    logic [15:0]         blk_sel;

    // Gates one enable per block with its own select bit.
    function automatic logic [15:0] fpv_gate(input logic        on,
                                             input logic [15:0] sel);
        fpv_gate = on ? sel : 16'h0000;
    endfunction

    // Release is synchronised so every flop leaves reset on one edge.
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    fpv_overlay_map u_map
    (
        .sel_hi_i   (s_r.wocr[`FPV_WOCR_SEL_HI]),
        .sel_lo_i   (s_r.wocr[`FPV_WOCR_SEL_LO]),
        .vpp_ok_i   (vpp_ok_i),
        .cpu_addr_i (cpu_addr_i),
        .hit_o      (map_hit),
        .ram_addr_o (map_addr)
    );

    always_comb
    begin
        s_nxt    = s_r;
        hw_prot  = !vpp_ok_i || standby_i;
        emu_prot = s_r.wocr[`FPV_WOCR_SEL_HI] ^
                   s_r.wocr[`FPV_WOCR_SEL_LO];
        allow    = !hw_prot && !emu_prot && !s_r.lock;
        int_evt  = nmi_i || (irq_i && !s_r.imask);
        setup    = psel_i && !penable_i;
        wr       = psel_i && penable_i && pwrite_i && s_r.pready;
        blk_sel  = {s_r.bsr2, s_r.bsr1};

        // The strap is read once, on the first edge after release.
        if (s_r.boot_pend)
        begin
            s_nxt.boot_pend = 1'b0;
            if (boot_mode_i)
            begin
                s_nxt.wocr[`FPV_WOCR_SEL_HI:`FPV_WOCR_SEL_LO] =
                    `FPV_BOOT_OVL;
                s_nxt.imask = 1'b1;
            end
        end

        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (setup)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0000_0000;
            case (paddr_i)
                `FPV_OFS_FCR:
                begin
                    s_nxt.prdata = {28'h000_0000, s_r.fcr};
                end
                `FPV_OFS_BSR1:
                begin
                    s_nxt.prdata = {24'h00_0000, s_r.bsr1};
                end
                `FPV_OFS_BSR2:
                begin
                    s_nxt.prdata = {24'h00_0000, s_r.bsr2};
                end
                `FPV_OFS_WOCR:
                begin
                    s_nxt.prdata = {24'h00_0000, s_r.wocr};
                end
                `FPV_OFS_STATUS:
                begin
                    s_nxt.prdata = {21'h00_0000, s_r.op, s_r.pwv_rdy,
                                    s_r.pwv, s_r.lock, emu_prot,
                                    hw_prot, vpp_ok_i, s_r.rd_inv};
                end
                `FPV_OFS_IMASK:
                begin
                    s_nxt.prdata = {31'h0000_0000, s_r.imask};
                end
                default:
                begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        if (wr)
        begin
            case (paddr_i)
                `FPV_OFS_FCR:
                begin
                    s_nxt.fcr = pwdata_i[3:0];
                end
                `FPV_OFS_BSR1:
                begin
                    s_nxt.bsr1 = pwdata_i[7:0];
                end
                `FPV_OFS_BSR2:
                begin
                    s_nxt.bsr2 = pwdata_i[7:0];
                end
                `FPV_OFS_WOCR:
                begin
                    s_nxt.wocr = pwdata_i[7:0];
                end
                `FPV_OFS_IMASK:
                begin
                    s_nxt.imask = pwdata_i[0];
                end
                default:
                begin
                    s_nxt.imask = s_nxt.imask;
                end
            endcase
        end

        // Placed after the bus write so hardware protection wins over writes to FCR, BSR1 and BSR2.
        if (hw_prot)
        begin
            s_nxt.fcr  = `FPV_RST_FCR;
            s_nxt.bsr1 = `FPV_RST_BSR;
            s_nxt.bsr2 = `FPV_RST_BSR;
        end

        case (s_r.op)
            fpv_pkg::FPV_OP_IDLE:
            begin
                if (s_nxt.fcr[`FPV_FCR_PROG] && allow)
                begin
                    s_nxt.op = fpv_pkg::FPV_OP_PROG;
                end
                else if (s_nxt.fcr[`FPV_FCR_ERASE] && allow)
                begin
                    s_nxt.op = fpv_pkg::FPV_OP_ERASE;
                end
            end
            fpv_pkg::FPV_OP_PROG:
            begin
                if (int_evt)
                begin
                    s_nxt.op   = fpv_pkg::FPV_OP_ABORT;
                    s_nxt.lock = 1'b1;
                end
                else if (!s_nxt.fcr[`FPV_FCR_PROG] || !allow)
                begin
                    s_nxt.op = fpv_pkg::FPV_OP_IDLE;
                end
            end
            fpv_pkg::FPV_OP_ERASE:
            begin
                if (int_evt)
                begin
                    s_nxt.op   = fpv_pkg::FPV_OP_ABORT;
                    s_nxt.lock = 1'b1;
                end
                else if (!s_nxt.fcr[`FPV_FCR_ERASE] || !allow)
                begin
                    s_nxt.op = fpv_pkg::FPV_OP_IDLE;
                end
            end
            fpv_pkg::FPV_OP_ABORT:
            begin
                s_nxt.op = fpv_pkg::FPV_OP_ABORT;
            end
            default:
            begin
                s_nxt.op = fpv_pkg::FPV_OP_IDLE;
            end
        endcase

        // Enables follow the next state so they drop with the abort edge.
        s_nxt.prog_en  = fpv_gate(s_nxt.op == fpv_pkg::FPV_OP_PROG,
                                  blk_sel);
        s_nxt.erase_en = fpv_gate(s_nxt.op == fpv_pkg::FPV_OP_ERASE,
                                  blk_sel);

        s_nxt.pv  = s_nxt.fcr[`FPV_FCR_PVER] && !hw_prot;
        s_nxt.ev  = s_nxt.fcr[`FPV_FCR_EVER] && !hw_prot;
        s_nxt.pwv = (s_nxt.fcr == 4'h0) && !hw_prot;
        s_nxt.rd_inv = s_nxt.fcr[`FPV_FCR_PROG] ||
                       s_nxt.fcr[`FPV_FCR_ERASE];

        // Software still owns the wait; this flag only shows it is over.
        if (!s_nxt.pwv)
        begin
            s_nxt.settle = 7'h00;
        end
        else if (s_r.settle != SETTLE_MAX)
        begin
            s_nxt.settle = s_r.settle + 7'h01;
        end
        s_nxt.pwv_rdy = s_nxt.pwv && (s_r.settle == SETTLE_MAX);

        s_nxt.ovl_hit  = map_hit;
        s_nxt.ovl_addr = map_addr;
    end

    always_ff @(posedge clock_i or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            s_r.op        <= fpv_pkg::FPV_OP_IDLE;
            s_r.fcr       <= `FPV_RST_FCR;
            s_r.bsr1      <= `FPV_RST_BSR;
            s_r.bsr2      <= `FPV_RST_BSR;
            s_r.wocr      <= `FPV_RST_WOCR;
            s_r.imask     <= 1'b0;
            s_r.lock      <= 1'b0;
            s_r.boot_pend <= 1'b1;
            s_r.settle    <= 7'h00;
            s_r.pready    <= 1'b0;
            s_r.pslverr   <= 1'b0;
            s_r.prdata    <= 32'h0000_0000;
            s_r.prog_en   <= 16'h0000;
            s_r.erase_en  <= 16'h0000;
            s_r.pv        <= 1'b0;
            s_r.ev        <= 1'b0;
            s_r.pwv       <= 1'b0;
            s_r.pwv_rdy   <= 1'b0;
            s_r.rd_inv    <= 1'b0;
            s_r.ovl_hit   <= 1'b0;
            s_r.ovl_addr  <= 16'h0000;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata_o       = s_r.prdata;
    assign pready_o       = s_r.pready;
    assign pslverr_o      = s_r.pslverr;
    assign prog_en_o      = s_r.prog_en;
    assign erase_en_o     = s_r.erase_en;
    assign pv_mode_o      = s_r.pv;
    assign ev_mode_o      = s_r.ev;
    assign pwv_mode_o     = s_r.pwv;
    assign pwv_ready_o    = s_r.pwv_rdy;
    assign read_invalid_o = s_r.rd_inv;
    assign locked_o       = s_r.lock;
    assign ovl_hit_o      = s_r.ovl_hit;
    assign ovl_addr_o     = s_r.ovl_addr;

endmodule

// ==== tb/fpv_cpu_model.sv ====
`timescale 1ns/1ns
module fpv_cpu_model
(
    input  wire logic        clock_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    input  wire logic [31:0] prdata_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [7:0]       paddr_o,
    output logic [31:0]      pwdata_o
);
    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end

    // One transfer; the caller enters just after a rising edge.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clock_i);
        penable_o <= 1'b1;
        // Only the bench watchdog ends a wait for an answer that never comes.
        do
        begin
            @(posedge clock_i);
        end
        while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released lines carry junk so stale values cannot pass.
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule

// ==== tb/fpv_top_chk.sv ====
`timescale 1ns/1ns
module fpv_top_chk
(
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        vpp_ok_i,
    input wire logic        standby_i,
    input wire logic        nmi_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [15:0] prog_en_o,
    input wire logic [15:0] erase_en_o,
    input wire logic        pv_mode_o,
    input wire logic        ev_mode_o,
    input wire logic        pwv_mode_o,
    input wire logic        pwv_ready_o,
    input wire logic        read_invalid_o,
    input wire logic        locked_o,
    input wire logic        ovl_hit_o,
    input wire logic [15:0] ovl_addr_o
);
    logic [7:0] pwv_cnt_r;
    logic       busy;

    default clocking dc @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    assign busy = |{prog_en_o, erase_en_o};

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pwv_cnt_r <= 8'h00;
        else if (!pwv_mode_o)
            pwv_cnt_r <= 8'h00;
        else if (pwv_cnt_r != 8'hff)
            pwv_cnt_r <= pwv_cnt_r + 8'h01;
    end

    a_hw_prot_off: assert property (
        (!vpp_ok_i || standby_i) [*2] |=>
        !busy && !pv_mode_o && !ev_mode_o && !pwv_mode_o)
        else $error("enables or verify on under hw protection");
    a_lock_sticky: assert property (locked_o |=> locked_o)
        else $error("lock cleared without reset");
    a_lock_blocks: assert property (locked_o |-> !busy)
        else $error("enable high while locked");
    a_nmi_abort: assert property (
        busy && nmi_i |=> locked_o && !busy)
        else $error("nmi did not abort at once");
    a_pwv_settle: assert property (
        pwv_ready_o |-> pwv_mode_o && pwv_cnt_r >= 8'h64)
        else $error("prewrite ready too early");
    a_pwv_excl: assert property (
        pwv_mode_o |-> !read_invalid_o && !pv_mode_o && !ev_mode_o)
        else $error("prewrite verify with other mode");
    a_ovl_addr: assert property (
        ovl_hit_o |-> $past(cpu_addr_i) < 16'h0180 &&
        ovl_addr_o == $past(cpu_addr_i) + 16'hf800)
        else $error("overlay hit or address wrong");
    a_ready_pulse: assert property (
        psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("ready not a one cycle answer");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");

    c_abort: cover property ($rose(locked_o));
    c_settle: cover property ($rose(pwv_ready_o));
    c_refuse: cover property (pslverr_o);
    c_overlay: cover property (ovl_hit_o);
endmodule

bind fpv_top fpv_top_chk u_chk (.*);

// ==== tb/test_flash_protect_and_verify_control.sv ====
`timescale 1ns/1ns
module test_flash_protect_and_verify_control;
    logic        clock_i, reset_n_i, psel_i, penable_i, pwrite_i;
    logic        pready_o, pslverr_o, vpp_ok_i, standby_i, boot_mode_i;
    logic        irq_i, nmi_i, pv_mode_o, ev_mode_o, pwv_mode_o, x;
    logic        pwv_ready_o, read_invalid_o, locked_o, ovl_hit_o, m_lock;
    logic [7:0]  paddr_i, m_wocr;
    logic [8:0]  p;
    logic [31:0] pwdata_i, prdata_o, seed;
    logic [15:0] cpu_addr_i, prog_en_o, erase_en_o, ovl_addr_o, m_bsr, a;
    logic [3:0]  m_fcr;
    int          fail_count, cmp_count, n;
    logic [15:0] atab [7] = '{16'h0006, 16'h007f, 16'h0080, 16'h00ff,
                              16'h0100, 16'h017f, 16'h0180};

    fpv_top DUT (.*);

    fpv_cpu_model cpu
    (
        .clock_i(clock_i), .pready_i(pready_o), .pslverr_i(pslverr_o),
        .prdata_i(prdata_o), .psel_o(psel_i), .penable_o(penable_i),
        .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i)
    );

    always #20 clock_i = ~clock_i;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        logic        hw;
        @(posedge clock_i);
        cpu.xfer(1'b1, ad, d, q, e);
        hw = !vpp_ok_i || standby_i;
        case (ad)
            8'h00: m_fcr = hw ? 4'h0 : d[3:0];
            8'h04: m_bsr[7:0] = hw ? 8'h00 : d[7:0];
            8'h08: m_bsr[15:8] = hw ? 8'h00 : d[7:0];
            8'h0c: m_wocr = d[7:0];
            default: ;
        endcase
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] xq,
                      input logic xe);
        logic [31:0] q;
        logic        e;
        @(posedge clock_i);
        cpu.xfer(1'b0, ad, 32'h0, q, e);
        chk(q, xq);
        chk(e, xe);
    endtask

    task automatic chk_out();
        logic        hw;
        logic [15:0] en;
        @(posedge clock_i);
        #1;
        hw = !vpp_ok_i || standby_i;
        en = (hw || m_lock || ^m_wocr[7:6]) ? 16'h0 : m_bsr;
        chk(prog_en_o, m_fcr[0] ? en : 16'h0);
        chk(erase_en_o, m_fcr[1] ? en : 16'h0);
        chk(pv_mode_o, m_fcr[2] && !hw);
        chk(ev_mode_o, m_fcr[3] && !hw);
        chk(pwv_mode_o, m_fcr == 4'h0 && !hw);
        chk(read_invalid_o, m_fcr[0] || m_fcr[1]);
        chk(locked_o, m_lock);
    endtask

    task automatic do_reset(input logic boot);
        @(posedge clock_i);
        reset_n_i <= 1'b0;
        boot_mode_i <= boot;
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        m_fcr = 4'h0;
        m_bsr = 16'h0;
        m_lock = 1'b0;
        m_wocr = boot ? 8'hc8 : 8'h08;
    endtask

    initial
    begin
        repeat (8000) @(posedge clock_i);
        fail_count++;
        results();
    end

    initial
    begin
        clock_i = 1'b0;
        reset_n_i = 1'b0;
        vpp_ok_i = 1'b1;
        standby_i = 1'b0;
        boot_mode_i = 1'b0;
        irq_i = 1'b0;
        nmi_i = 1'b0;
        cpu_addr_i = 16'h0000;
        fail_count = 0;
        cmp_count = 0;
        seed = 32'h8c4e2a5a;
        do_reset(1'b0);
        rd(8'h00, 32'h0, 1'b0);
        rd(8'h0c, 32'h08, 1'b0);
        rd(8'h18, 32'h0, 1'b1);
        rd(8'h10, 32'ha2, 1'b0);
        wr(8'h00, 32'h1);
        chk_out();
        wr(8'h00, 32'h0);
        chk_out();
        // Software holds off reading until the settle time is over.
        n = 1;
        while (pwv_ready_o !== 1'b1 && n < 300)
        begin
            @(posedge clock_i);
            n++;
        end
        chk(n, 32'd101);
        for (int i = 0; i < 20; i++)
        begin
            wr(8'h0c, {24'h0, 2'(i / 5), 6'h08});
            wr(8'h04, i == 0 ? 32'h0 : rnd() & 32'hff);
            wr(8'h08, i == 0 ? 32'h0 : rnd() & 32'hff);
            wr(8'h00, 32'h1 << (i % 5));
            chk_out();
        end
        wr(8'h0c, 32'h08);
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h04, 32'h5a);
            wr(8'h08, 32'ha5);
            wr(8'h00, 32'h2);
            chk_out();
            @(posedge clock_i);
            vpp_ok_i <= (k == 1);
            standby_i <= (k == 1);
            m_fcr = 4'h0;
            m_bsr = 16'h0;
            repeat (2) @(posedge clock_i);
            chk_out();
            wr(8'h04, 32'hff);
            rd(8'h04, 32'h0, 1'b0);
            @(posedge clock_i);
            vpp_ok_i <= 1'b1;
            standby_i <= 1'b0;
        end
        wr(8'h14, 32'h1);
        wr(8'h04, 32'h81);
        wr(8'h00, 32'h1);
        @(posedge clock_i);
        irq_i <= 1'b1;
        chk_out();
        @(posedge clock_i);
        irq_i <= 1'b0;
        nmi_i <= 1'b1;
        @(posedge clock_i);
        nmi_i <= 1'b0;
        m_lock = 1'b1;
        chk_out();
        wr(8'h00, 32'h4);
        chk_out();
        wr(8'h00, 32'h1);
        rd(8'h04, 32'h81, 1'b0);
        chk_out();
        do_reset(1'b1);
        rd(8'h0c, 32'hc8, 1'b0);
        rd(8'h14, 32'h1, 1'b0);
        // The vector slot comes from RAM; the handler sits above flash.
        @(posedge clock_i);
        cpu_addr_i <= 16'h0006;
        @(posedge clock_i);
        cpu_addr_i <= 16'hf780;
        #1;
        chk(ovl_hit_o, 1'b1);
        chk(ovl_addr_o, 32'hf806);
        @(posedge clock_i);
        #1;
        chk(ovl_hit_o, 1'b0);
        wr(8'h14, 32'h0);
        wr(8'h08, 32'hff);
        wr(8'h00, 32'h2);
        chk_out();
        @(posedge clock_i);
        irq_i <= 1'b1;
        @(posedge clock_i);
        irq_i <= 1'b0;
        m_lock = 1'b1;
        chk_out();
        for (int w = 0; w < 4; w++)
        begin
            wr(8'h0c, {24'h0, 2'(w), 6'h08});
            for (int j = 0; j < 8; j++)
            begin
                a = j < 7 ? atab[j] : 16'(rnd() & 32'h1ff);
                p = a[15:7];
                @(posedge clock_i);
                cpu_addr_i <= a;
                @(posedge clock_i);
                #1;
                x = (w == 3) ? p == 9'h000 :
                    (w != 0 && p == 9'h001) || (w == 2 && p == 9'h002);
                chk(ovl_hit_o, x);
                chk(ovl_addr_o, a + 16'hf800);
            end
        end
        @(posedge clock_i);
        vpp_ok_i <= 1'b0;
        cpu_addr_i <= 16'h0006;
        repeat (2) @(posedge clock_i);
        #1;
        chk(ovl_hit_o, 1'b0);
        @(posedge clock_i);
        vpp_ok_i <= 1'b1;
        wr(8'h0c, 32'h08);
        rd(8'h0c, 32'h08, 1'b0);
        results();
    end
endmodule
